/* pofc_pkg.sv */
// pofc_pkg: constants shared by the pulse output / count stop block.
// assumes a 10 MHz system clock; the other files take their offsets, limits and codes from here.
`default_nettype none

package pofc_pkg;

	// ==================================================================
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_OUT_SELECT   = 8'h00;
	localparam logic [7:0] OFS_PULSE_FS     = 8'h04;
	localparam logic [7:0] OFS_STOP_FUNC    = 8'h08;
	localparam logic [7:0] OFS_COUNT_TARGET = 8'h0c;
	localparam logic [7:0] OFS_COMP_DELAY   = 8'h10;
	localparam logic [7:0] OFS_STATUS       = 8'h14;
	localparam logic [7:0] OFS_PULSE_COUNT  = 8'h18;
	localparam logic [7:0] OFS_CARRY        = 8'h1c;

	// ==================================================================
	// reset values and legal ranges
	localparam logic [4:0]  RST_OUT_SELECT   = 5'h00;
	localparam logic [13:0] RST_PULSE_FS     = 14'h1388;  // 5000 Hz
	localparam logic [13:0] MIN_PULSE_FS     = 14'h0096;  // 150 Hz
	localparam logic [13:0] MAX_PULSE_FS     = 14'h2710;  // 10000 Hz
	localparam logic [2:0]  RST_STOP_FUNC    = 3'h0;
	localparam logic [2:0]  MAX_STOP_FUNC    = 3'h5;
	localparam logic [19:0] RST_COUNT_TARGET = 20'h186a0; // 100000 pulses
	localparam logic [19:0] MAX_COUNT_TARGET = 20'hf423f; // 999999 pulses
	localparam logic [6:0]  RST_COMP_DELAY   = 7'h0a;     // 10 ms
	localparam logic [6:0]  MAX_COMP_DELAY   = 7'h64;     // 100 ms

	// ==================================================================
	// output selection codes
	localparam logic [4:0] SEL_NONE      = 5'h00;
	localparam logic [4:0] SEL_PULSE_REF = 5'h15;
	localparam logic [4:0] SEL_PULSE_FB  = 5'h1a;
	localparam logic [4:0] SEL_PULSE_OF  = 5'h1b;
	localparam logic [4:0] SEL_PULSE_CUR = 5'h1c;
	localparam logic [4:0] SEL_PULSE_PWR = 5'h1d;
	localparam logic [4:0] SEL_PULSE_TMP = 5'h1e;
	localparam logic [4:0] SEL_CTRL_BIT  = 5'h1f;
	localparam int         CTRL_BIT_POS  = 12;

	// heatsink temperature scale in degrees C
	localparam logic [15:0] TEMP_LOW  = 16'h0014; // 20
	localparam logic [15:0] TEMP_HIGH = 16'h0064; // 100

	// ==================================================================
	// timing
	localparam longint CLK_HZ     = 10000000;
	localparam longint MS_PER_S   = 1000;
	localparam longint CYC_PER_MS = CLK_HZ / MS_PER_S;

	// stop sequencer, gray coded along idle-run-delay-ramp
	typedef enum logic [1:0] {
		POFC_IDLE  = 2'b00,
		POFC_RUN   = 2'b01,
		POFC_DELAY = 2'b11,
		POFC_RAMP  = 2'b10
	} pofc_state_t;

endpackage : pofc_pkg

`default_nettype wire

/* pofc_top.sv */
// pofc_top: configurable digital / pulse frequency output and precise-stop pulse counter.
// assumes measurements, status and commands come from the drive core on clk;
// only the counting input is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none

module pofc_top #(
	parameter int VAL_W = 16
) (
	// clock, reset, enable
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output logic      [31:0]      reg_rdata,
	// drive status and control word
	input  wire logic [25:0]      status_cond,
	input  wire logic [15:0]      ctrl_word,
	// measured quantities and their scaling bounds
	input  wire logic [VAL_W-1:0] ref_value,
	input  wire logic [VAL_W-1:0] ref_min,
	input  wire logic [VAL_W-1:0] ref_max,
	input  wire logic [VAL_W-1:0] feedback_value,
	input  wire logic [VAL_W-1:0] feedback_lower_bound,
	input  wire logic [VAL_W-1:0] feedback_upper_bound,
	input  wire logic [VAL_W-1:0] output_freq,
	input  wire logic [VAL_W-1:0] output_freq_high_limit,
	input  wire logic [VAL_W-1:0] output_current,
	input  wire logic [VAL_W-1:0] inverter_rated_current,
	input  wire logic [VAL_W-1:0] output_power,
	input  wire logic [VAL_W-1:0] motor_rated_power,
	input  wire logic [VAL_W-1:0] heatsink_temp,
	// stop control
	input  wire logic             start_cmd,
	input  wire logic             stop_cmd,
	input  wire logic             standstill,
	input  wire logic             count_pin,
	// outputs
	output logic                  digital_out,
	output logic                  internal_stop
);

	localparam int NUM_W = VAL_W + 15;
	localparam int DEN_W = VAL_W + 24;
	localparam int ACC_W = DEN_W + 1;
	localparam int DLY_W = 20 + VAL_W + 1;
	localparam logic [23:0] CLK_HZ_W = 24'(pofc_pkg::CLK_HZ);
	localparam logic [13:0] CYC_MS_W = 14'(pofc_pkg::CYC_PER_MS);

	// ==================================================================
	// functions

	// clamp a value into [lo,hi] and return its offset from lo
	function automatic logic [VAL_W-1:0] span_num(input logic [VAL_W-1:0] v,
		input logic [VAL_W-1:0] lo, input logic [VAL_W-1:0] hi);
		logic [VAL_W-1:0] r;
		r = '0;
		if (hi <= lo)
			r = '0;
		else if (v <= lo)
			r = '0;
		else if (v >= hi)
			r = hi - lo;
		else
			r = v - lo;
		return r;
	endfunction : span_num

	// width of the interval, never zero so the accumulator never wraps every cycle
	function automatic logic [VAL_W-1:0] span_den(input logic [VAL_W-1:0] lo,
		input logic [VAL_W-1:0] hi);
		logic [VAL_W-1:0] r;
		r = '0;
		if (hi <= lo)
			r = {{(VAL_W-1){1'b0}}, 1'b1};
		else
			r = hi - lo;
		return r;
	endfunction : span_den

	// ==================================================================
	// registers
	logic [4:0]  out_select;
	logic [13:0] pulse_fs;
	logic [2:0]  stop_func;
	logic [19:0] count_target;
	logic [6:0]  comp_delay;
	logic        wr_hit;

	assign wr_hit = ce && reg_write;

	// software configuration; out-of-range writes are clamped, except out_select, which keeps only the low 5 bits
	always_ff @(posedge clk) begin
		if (reset) begin
			out_select   <= pofc_pkg::RST_OUT_SELECT;
			pulse_fs     <= pofc_pkg::RST_PULSE_FS;
			stop_func    <= pofc_pkg::RST_STOP_FUNC;
			count_target <= pofc_pkg::RST_COUNT_TARGET;
			comp_delay   <= pofc_pkg::RST_COMP_DELAY;
		end else if (wr_hit) begin
			case (reg_addr)
				pofc_pkg::OFS_OUT_SELECT: begin
					out_select <= reg_wdata[4:0];
				end
				pofc_pkg::OFS_PULSE_FS: begin
					if (reg_wdata[31:0] < 32'(pofc_pkg::MIN_PULSE_FS))
						pulse_fs <= pofc_pkg::MIN_PULSE_FS;
					else if (reg_wdata[31:0] > 32'(pofc_pkg::MAX_PULSE_FS))
						pulse_fs <= pofc_pkg::MAX_PULSE_FS;
					else
						pulse_fs <= reg_wdata[13:0];
				end
				pofc_pkg::OFS_STOP_FUNC: begin
					if (reg_wdata[31:0] > 32'(pofc_pkg::MAX_STOP_FUNC))
						stop_func <= pofc_pkg::MAX_STOP_FUNC;
					else
						stop_func <= reg_wdata[2:0];
				end
				pofc_pkg::OFS_COUNT_TARGET: begin
					if (reg_wdata[31:0] > 32'(pofc_pkg::MAX_COUNT_TARGET))
						count_target <= pofc_pkg::MAX_COUNT_TARGET;
					else
						count_target <= reg_wdata[19:0];
				end
				pofc_pkg::OFS_COMP_DELAY: begin
					if (reg_wdata[31:0] > 32'(pofc_pkg::MAX_COMP_DELAY))
						comp_delay <= pofc_pkg::MAX_COMP_DELAY;
					else
						comp_delay <= reg_wdata[6:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ==================================================================
	// output selection
	logic [VAL_W-1:0] sel_num;
	logic [VAL_W-1:0] sel_den;
	logic             pulse_mode;
	logic             level_out;

	// pick the quantity to scale and the interval it spans
	always_comb begin
		sel_num    = '0;
		sel_den    = {{(VAL_W-1){1'b0}}, 1'b1};
		pulse_mode = 1'b1;
		level_out  = 1'b0;
		case (out_select)
			pofc_pkg::SEL_NONE: begin
				pulse_mode = 1'b0;
				level_out  = 1'b0;
			end
			pofc_pkg::SEL_PULSE_REF: begin
				sel_num = span_num(ref_value, ref_min, ref_max);
				sel_den = span_den(ref_min, ref_max);
			end
			pofc_pkg::SEL_PULSE_FB: begin
				sel_num = span_num(feedback_value, feedback_lower_bound, feedback_upper_bound);
				sel_den = span_den(feedback_lower_bound, feedback_upper_bound);
			end
			pofc_pkg::SEL_PULSE_OF: begin
				sel_num = span_num(output_freq, '0, output_freq_high_limit);
				sel_den = span_den('0, output_freq_high_limit);
			end
			pofc_pkg::SEL_PULSE_CUR: begin
				sel_num = span_num(output_current, '0, inverter_rated_current);
				sel_den = span_den('0, inverter_rated_current);
			end
			pofc_pkg::SEL_PULSE_PWR: begin
				sel_num = span_num(output_power, '0, motor_rated_power);
				sel_den = span_den('0, motor_rated_power);
			end
			pofc_pkg::SEL_PULSE_TMP: begin
				sel_num = span_num(heatsink_temp, VAL_W'(pofc_pkg::TEMP_LOW),
					VAL_W'(pofc_pkg::TEMP_HIGH));
				sel_den = span_den(VAL_W'(pofc_pkg::TEMP_LOW), VAL_W'(pofc_pkg::TEMP_HIGH));
			end
			pofc_pkg::SEL_CTRL_BIT: begin
				pulse_mode = 1'b0;
				level_out  = ctrl_word[pofc_pkg::CTRL_BIT_POS];
			end
			default: begin
				// codes 1-20 and 22-25 mirror the status list
				pulse_mode = 1'b0;
				level_out  = status_cond[out_select];
			end
		endcase
	end

	// ==================================================================
	// phase accumulator: adds 2*num*fs each cycle and wraps at den*fclk,
	// each wrap toggles the output, giving a square wave of num*fs/den Hz.
	// the accumulator restarts only under a level selection, so on a pulse config
	// change the running half period simply continues at the new rate instead of glitching.
	logic [NUM_W-1:0] acc_step;
	logic [DEN_W-1:0] acc_wrap;
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;
	logic             pulse_level;

	assign acc_step = NUM_W'({sel_num, 1'b0} * pulse_fs);
	assign acc_wrap = DEN_W'(sel_den * CLK_HZ_W);
	assign next_acc = acc + ACC_W'(acc_step);

	always_ff @(posedge clk) begin
		if (reset) begin
			acc         <= '0;
			pulse_level <= 1'b0;
		end else if (ce) begin
			if (!pulse_mode) begin
				acc         <= '0;
				pulse_level <= 1'b0;
			end else if (next_acc >= ACC_W'(acc_wrap)) begin
				acc         <= next_acc - ACC_W'(acc_wrap);
				pulse_level <= ~pulse_level;
			end else begin
				acc <= next_acc;
			end
		end
	end

	// registered output pin
	always_ff @(posedge clk) begin
		if (reset)
			digital_out <= 1'b0;
		else if (ce)
			digital_out <= pulse_mode ? pulse_level : level_out;
	end

	// ==================================================================
	// counting input: two-stage synchroniser then edge detect.
	// at 10 MHz a 67.6 kHz input leaves ~74 cycles per half period.
	logic cnt_meta;
	logic cnt_sync;
	logic cnt_prev;
	logic cnt_edge;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_meta <= 1'b0;
			cnt_sync <= 1'b0;
			cnt_prev <= 1'b0;
		end else if (ce) begin
			cnt_meta <= count_pin;
			cnt_sync <= cnt_meta;
			cnt_prev <= cnt_sync;
		end
	end

	assign cnt_edge = cnt_sync && !cnt_prev;

	// start and stop edges from the core
	logic start_prev;
	logic stop_prev;
	logic start_edge;
	logic stop_edge;

	always_ff @(posedge clk) begin
		if (reset) begin
			start_prev <= 1'b0;
			stop_prev  <= 1'b0;
		end else if (ce) begin
			start_prev <= start_cmd;
			stop_prev  <= stop_cmd;
		end
	end

	assign start_edge = start_cmd && !start_prev;
	assign stop_edge  = stop_cmd && !stop_prev;

	// ==================================================================
	// stop sequencer: idle, run, optional speed-compensation delay, ramp to standstill.
	// counter modes are 1,2,4,5; speed-compensated modes are 3,4,5
	function automatic logic is_comp_mode(input logic [2:0] f);
		return (f == 3'h3) || (f == 3'h4) || (f == 3'h5);
	endfunction : is_comp_mode

	pofc_pkg::pofc_state_t state;
	pofc_pkg::pofc_state_t next_state;
	logic [19:0]      pulse_count;
	logic [19:0]      ramp_count;
	logic [19:0]      carry_count;
	logic [19:0]      eff_target;
	logic [VAL_W-1:0] speed_gap;
	logic [DLY_W-1:0] dly_acc;
	logic [DLY_W-1:0] dly_goal;
	logic [DLY_W-1:0] next_goal;
	logic [DLY_W-1:0] dly_step;
	logic             count_hit;
	logic             stop_req;

	// the carried ramp-down pulses shorten the next run, never below zero
	assign eff_target = (carry_count >= count_target) ? 20'h0 : count_target - carry_count;
	assign count_hit  = (stop_func == 3'h1 || stop_func == 3'h2 || stop_func == 3'h4 || stop_func == 3'h5)
		&& (pulse_count + 20'(cnt_edge) >= eff_target);
	assign stop_req   = stop_edge || count_hit;
	// delay scales with the speed deficit: accumulate fmax per cycle up to delay*(fmax-f)
	assign speed_gap  = (output_freq >= output_freq_high_limit) ? '0 : output_freq_high_limit - output_freq;
	assign dly_step   = DLY_W'(output_freq_high_limit);
	assign next_goal  = is_comp_mode(stop_func) ?
		DLY_W'(DLY_W'(comp_delay) * DLY_W'(CYC_MS_W) * DLY_W'(speed_gap)) : '0;

	always_comb begin
		next_state = state;
		case (state)
			pofc_pkg::POFC_IDLE: begin
				if (start_edge)
					next_state = pofc_pkg::POFC_RUN;
			end
			pofc_pkg::POFC_RUN: begin
				if (stop_req && next_goal != '0)
					next_state = pofc_pkg::POFC_DELAY;
				else if (stop_req)
					next_state = pofc_pkg::POFC_RAMP;
			end
			pofc_pkg::POFC_DELAY: begin
				if (dly_acc + dly_step >= dly_goal)
					next_state = pofc_pkg::POFC_RAMP;
			end
			pofc_pkg::POFC_RAMP: begin
				if (standstill)
					next_state = pofc_pkg::POFC_IDLE;
			end
			default: begin
				next_state = pofc_pkg::POFC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state         <= pofc_pkg::POFC_IDLE;
			internal_stop <= 1'b0;
		end else if (ce) begin
			state         <= next_state;
			internal_stop <= next_state == pofc_pkg::POFC_RAMP;
		end
	end

	// run pulses, cleared on the start edge only, so a held start never re-arms
	always_ff @(posedge clk) begin
		if (reset)
			pulse_count <= '0;
		else if (ce && state == pofc_pkg::POFC_IDLE && start_edge)
			pulse_count <= '0;
		else if (ce && state == pofc_pkg::POFC_RUN && cnt_edge && pulse_count != pofc_pkg::MAX_COUNT_TARGET)
			pulse_count <= pulse_count + 20'h1;
	end

	// ramp-down pulses: dropped in reset modes, carried in no-reset modes
	always_ff @(posedge clk) begin
		if (reset) begin
			ramp_count  <= '0;
			carry_count <= '0;
		end else if (ce) begin
			if (state != pofc_pkg::POFC_RAMP) begin
				ramp_count <= '0;
			end else if (standstill) begin
				ramp_count  <= '0;
				carry_count <= (stop_func == 3'h2 || stop_func == 3'h5) ? ramp_count : 20'h0;
			end else if (cnt_edge && ramp_count != pofc_pkg::MAX_COUNT_TARGET) begin
				ramp_count <= ramp_count + 20'h1;
			end
		end
	end

	// the goal is latched while running so a speed change during the delay is ignored
	always_ff @(posedge clk) begin
		if (reset) begin
			dly_acc  <= '0;
			dly_goal <= '0;
		end else if (ce && state == pofc_pkg::POFC_RUN) begin
			dly_acc  <= '0;
			dly_goal <= next_goal;
		end else if (ce && state == pofc_pkg::POFC_DELAY) begin
			dly_acc <= dly_acc + dly_step;
		end
	end

	// ==================================================================
	// read port: data stand for one cycle after the strobe, zero otherwise
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			pofc_pkg::OFS_OUT_SELECT:   rd_mux = 32'(out_select);
			pofc_pkg::OFS_PULSE_FS:     rd_mux = 32'(pulse_fs);
			pofc_pkg::OFS_STOP_FUNC:    rd_mux = 32'(stop_func);
			pofc_pkg::OFS_COUNT_TARGET: rd_mux = 32'(count_target);
			pofc_pkg::OFS_COMP_DELAY:   rd_mux = 32'(comp_delay);
			pofc_pkg::OFS_STATUS:       rd_mux = 32'({internal_stop, 2'(state)});
			pofc_pkg::OFS_PULSE_COUNT:  rd_mux = 32'(pulse_count);
			pofc_pkg::OFS_CARRY:        rd_mux = 32'(carry_count);
			default:                    rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset)
			reg_rdata <= '0;
		else if (ce)
			reg_rdata <= reg_read ? rd_mux : 32'h0;
	end
endmodule : pofc_top

`default_nettype wire

/* pofc_top_properties.sv */
// pofc_top_properties: port-level checks of the pulse output / count stop block.
// assumes it is bound to pofc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module pofc_top_properties (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	// drive side
	input wire logic [25:0] status_cond,
	input wire logic [15:0] ctrl_word,
	input wire logic        start_cmd,
	input wire logic        count_pin,
	input wire logic        digital_out,
	input wire logic        internal_stop
);
	// ==================================================================
	// configuration shadow
	logic [4:0]  sel;
	logic [2:0]  func;
	logic [19:0] tgt;
	logic [3:0]  age;
	logic        armed;
	logic [19:0] cnt;
	logic        start_d;

	// age saturates, so a settled selection is told from a fresh one
	always_ff @(posedge clk) begin
		if (reset) begin
			sel  <= pofc_pkg::RST_OUT_SELECT;
			func <= pofc_pkg::RST_STOP_FUNC;
			tgt  <= pofc_pkg::RST_COUNT_TARGET;
			age  <= 4'h0;
		end else begin
			if (reg_write && reg_addr == pofc_pkg::OFS_OUT_SELECT) sel <= reg_wdata[4:0];
			if (reg_write && reg_addr == pofc_pkg::OFS_STOP_FUNC) func <= reg_wdata[2:0];
			if (reg_write && reg_addr == pofc_pkg::OFS_COUNT_TARGET) tgt <= reg_wdata[19:0];
			age <= (reg_write && reg_addr == pofc_pkg::OFS_OUT_SELECT) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
		end
	end

	// raw pin-high cycles since the start edge; never fewer than the edges the block saw
	always_ff @(posedge clk) begin
		start_d <= start_cmd;
		if (reset) begin
			armed <= 1'b0;
			cnt   <= 20'h0;
		end else if (start_cmd && !start_d) begin
			armed <= 1'b1;
			cnt   <= 20'h0;
		end else if (count_pin) begin
			cnt <= cnt + 20'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ==================================================================
	// assertions
	a_none_quiet: assert property (sel == pofc_pkg::SEL_NONE && age > 2 |-> !digital_out)
		else $error("output active with no selection");
	a_status_follow: assert property (((sel != 0 && sel < 21) || (sel > 21 && sel < 26)) && age > 2
		&& $stable(status_cond) [*3] |-> digital_out == status_cond[sel]) else $error("status not followed");
	a_ctrl_follow: assert property ((sel == pofc_pkg::SEL_CTRL_BIT && age > 2 && $stable(ctrl_word)) [*3]
		|-> digital_out == ctrl_word[12]) else $error("control bit not followed");
	a_func_readback: assert property (reg_read && reg_addr == pofc_pkg::OFS_STOP_FUNC |=> reg_rdata[2:0] == func)
		else $error("stop function readback wrong");
	a_target_readback: assert property (reg_read && reg_addr == pofc_pkg::OFS_COUNT_TARGET |=> reg_rdata[19:0] == tgt)
		else $error("target readback wrong");
	a_stop_armed: assert property ($rose(internal_stop) |-> armed)
		else $error("stop without start edge");
	a_stop_count: assert property ($rose(internal_stop) && (func == 1 || func == 4) |-> cnt >= tgt)
		else $error("stop before target count");
	a_stop_timely: assert property (armed && func == 1 && $changed(cnt) && cnt == tgt |-> ##[0:8] internal_stop)
		else $error("stop late after target");

	c_pulse: cover property (sel == pofc_pkg::SEL_PULSE_OF && $rose(digital_out));
	c_stop: cover property (func == 1 && $rose(internal_stop));
	c_ctrl: cover property (sel == pofc_pkg::SEL_CTRL_BIT && $rose(digital_out));
endmodule : pofc_top_properties

`default_nettype wire

/* pofc_drive_model.sv */
// pofc_drive_model: drive core stand-in giving counting pulses and standstill.
// assumes one clock shared with the block.
`timescale 1ns/1ps
`default_nettype none

module pofc_drive_model (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// pulse source
	input wire logic        pulse_en,
	input wire logic [15:0] period,
	// stop handshake
	input wire logic        internal_stop,
	output logic            count_pin,
	output logic            standstill
);
	logic [15:0] tick;
	logic [7:0]  ramp;

	// one-cycle pulse each period; 148 cycles is the fastest legal rate
	always_ff @(posedge clk) begin
		if (reset || !pulse_en) begin
			tick      <= 16'h0;
			count_pin <= 1'b0;
		end else begin
			count_pin <= tick == 16'h0;
			tick      <= (tick == period - 16'h1) ? 16'h0 : tick + 16'h1;
		end
	end

	// ramp-down takes 60 cycles; pulses keep coming meanwhile, as on a real axis
	always_ff @(posedge clk) begin
		if (reset || !pulse_en) begin
			ramp       <= 8'h0;
			standstill <= 1'b0;
		end else if (ramp != 8'h0) begin
			ramp       <= (ramp == 8'h3c) ? 8'h0 : ramp + 8'h1;
			standstill <= ramp == 8'h3c;
		end else if (internal_stop && !standstill) begin
			ramp <= 8'h1;
		end
	end
endmodule : pofc_drive_model

`default_nettype wire

/* tb_pofc_top.sv */
// tb_pofc_top: self-checking bench for the pulse output / count stop block.
// assumes pofc_pkg, pofc_top, the checker and the drive model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_pofc_top;
	localparam int WIN = 10000;
	logic        clk, reset, reg_write, reg_read, start_cmd, pulse_en, gate, digital_out, internal_stop;
	logic        count_pin, standstill, ce, stop_cmd, dout_d;
	logic [15:0] lo_b = 16'h64;
	logic [15:0] hi_b = 16'h44c;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [25:0] status_cond;
	logic [15:0] ctrl_word, rnd, qv, tq;
	logic [4:0]  sels [6] = '{5'h15, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
	logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	logic [31:0] rstv [5] = '{32'h0, 32'h1388, 32'h0, 32'h186a0, 32'ha};
	int          failures, samples_checked, cycles, pulses, pins, i, n, num, den;
	longint      e;

	pofc_top i_pofc_top (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .status_cond(status_cond),
		.ctrl_word(ctrl_word), .ref_value(qv), .ref_min(lo_b), .ref_max(hi_b), .feedback_value(qv),
		.feedback_lower_bound(lo_b), .feedback_upper_bound(hi_b), .output_freq(qv),
		.output_freq_high_limit(hi_b), .output_current(qv), .inverter_rated_current(hi_b),
		.output_power(qv), .motor_rated_power(hi_b), .heatsink_temp(tq), .start_cmd(start_cmd),
		.stop_cmd(stop_cmd), .standstill(standstill), .count_pin(count_pin), .digital_out(digital_out),
		.internal_stop(internal_stop));
	pofc_drive_model i_pofc_drive_model (.clk(clk), .reset(reset), .pulse_en(pulse_en), .period(16'h94),
		.internal_stop(internal_stop), .count_pin(count_pin), .standstill(standstill));

	// ==================================================================
	// clock, hang limit and edge counters
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (gate && digital_out && !dout_d) pulses++;
		dout_d = digital_out;
		if (start_cmd && count_pin) pins++;
		if (cycles == 90000) begin
			failures++;
			test_done;
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		check("reg_rdata", x, reg_rdata);
	endtask : rd

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// ==================================================================
	// main sequence
	initial begin
		{reset, reg_write, reg_read, start_cmd, pulse_en, gate} = 6'h20;
		{ce, stop_cmd, dout_d} = 3'h4;
		{reg_addr, reg_wdata, status_cond, ctrl_word} = '0;
		{qv, tq, rnd} = {16'h0, 16'h0, 16'hfc0a};
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 5; i++) rd(ofs[i], rstv[i]);
		for (i = 0; i < 6; i++) begin
			wr(pofc_pkg::OFS_STOP_FUNC, 32'(i));
			rd(pofc_pkg::OFS_STOP_FUNC, 32'(i));
		end
		wr(pofc_pkg::OFS_COUNT_TARGET, 32'hf423f);
		rd(pofc_pkg::OFS_COUNT_TARGET, 32'hf423f);
		wr(pofc_pkg::OFS_COMP_DELAY, 32'h64);
		rd(pofc_pkg::OFS_COMP_DELAY, 32'h64);
		wr(pofc_pkg::OFS_PULSE_FS, 32'h96);
		wr(8'hfc, 32'hffffffff);
		rd(pofc_pkg::OFS_PULSE_FS, 32'h96);
		// status selections, with random conditions
		for (i = 0; i < 26; i++) if (i != 21) begin
			wr(pofc_pkg::OFS_OUT_SELECT, 32'(i));
			rnd = lfsr(rnd);
			status_cond <= {rnd[9:0], rnd};
			repeat (4) @(posedge clk);
			@(negedge clk);
			check("digital_out", (i == 0) ? 32'h0 : 32'(status_cond[i]), 32'(digital_out));
		end
		wr(pofc_pkg::OFS_OUT_SELECT, 32'h1f);
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			ctrl_word <= rnd;
			repeat (4) @(posedge clk);
			@(negedge clk);
			check("digital_out", 32'(ctrl_word[12]), 32'(digital_out));
		end
		// pulse modes at full-scale 10000 Hz, counted over a fixed window
		wr(pofc_pkg::OFS_PULSE_FS, 32'h2710);
		for (i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			n = int'(rnd) % 1001;
			qv <= 16'(100 + n);
			tq <= 16'(20 + n % 81);
			num = (i < 2) ? n : (i == 5 ? n % 81 : 100 + n);
			den = (i < 2) ? 1000 : (i == 5 ? 80 : 1100);
			wr(pofc_pkg::OFS_OUT_SELECT, 32'(sels[i]));
			repeat (100) @(posedge clk);
			pulses = 0;
			gate <= 1'b1;
			repeat (WIN) @(posedge clk);
			gate <= 1'b0;
			e = longint'(10000) * WIN * num / (den * pofc_pkg::CLK_HZ);
			samples_checked++;
			if (pulses > e + 1 || pulses + 1 < e) begin
				failures++;
				$display("[FAIL] pulse count expected %0d seen %0d", e, pulses);
			end
		end
		// counter stop with reset; pulses before the start edge must not count
		wr(pofc_pkg::OFS_OUT_SELECT, 32'h0);
		wr(pofc_pkg::OFS_STOP_FUNC, 32'h1);
		wr(pofc_pkg::OFS_COUNT_TARGET, 32'h14);
		pulse_en <= 1'b1;
		repeat (3000) @(posedge clk);
		check("internal_stop", 32'h0, 32'(internal_stop));
		// start well clear of a pin so the start edge is unambiguous
		@(posedge clk iff count_pin);
		repeat (70) @(posedge clk);
		pins = 0;
		start_cmd <= 1'b1;
		for (i = 0; i < 5000 && internal_stop !== 1'b1; i++) @(posedge clk);
		check("pins_at_stop", 32'h14, 32'(pins));
		for (i = 0; i < 300 && standstill !== 1'b1; i++) @(posedge clk);
		check("standstill", 32'h1, 32'(standstill));
		start_cmd <= 1'b0;
		pulse_en <= 1'b0;
		rd(pofc_pkg::OFS_CARRY, 32'h0);
		// speed-compensated stop at half speed, 1 ms delay: 5000 cycles late
		wr(pofc_pkg::OFS_STOP_FUNC, 32'h3);
		wr(pofc_pkg::OFS_COMP_DELAY, 32'h1);
		qv <= 16'h226;
		start_cmd <= 1'b1;
		repeat (2) @(posedge clk);
		stop_cmd <= 1'b1;
		repeat (4900) @(posedge clk);
		check("internal_stop", 32'h0, 32'(internal_stop));
		repeat (200) @(posedge clk);
		check("internal_stop", 32'h1, 32'(internal_stop));
		{start_cmd, stop_cmd} <= 2'b00;
		test_done;
	end
endmodule : tb_pofc_top

bind pofc_top pofc_top_properties i_pofc_top_properties (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.status_cond(status_cond), .ctrl_word(ctrl_word), .start_cmd(start_cmd), .count_pin(count_pin),
	.digital_out(digital_out), .internal_stop(internal_stop));

`default_nettype wire
